//--- core/fsp_sequencer.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) page address latched at operation start; pointer free afterwards
// (RULE2) lock bit set ignores the pointer completely
// (RULE3) byte select bit used by readback loads, ignored by stores
// (RULE4) erase: code X0000011 then store within four cycles, page field only
// (RULE5) erase of halting section halts cpu; concurrent section erase does not
// (RULE6) load: code 00000001 then store puts data pair into buffer word
// (RULE7) buffer cleared after page write, on read re-enable, on reset
// (RULE8) software loads each buffer word at most once between clears
// (RULE9) eeprom write during loading discards loaded words
// (RULE10) write: code X0000101 then store, buffer to page field
// (RULE11) page write to halting section halts cpu, concurrent section runs
// (RULE12) interrupt request held while enabled and store enable clear
// (RULE13) erase or write blocks concurrent section reads, busy flag set
// (RULE14) software re-enables section before reading it after programming
// (RULE15) lock set: code X0001001, store, programs bits where data 5..2 zero
// (RULE16) software should use pointer 0x0001 and ones in bits 7,6,1,0
// (RULE17) lock programming keeps whole flash readable, no halt
// (RULE18) eeprom write refuses self-programming and fuse/lock readback
// (RULE19) pointer 0x0001 readback load within three cycles returns lock bits
// (RULE20) pointer 0x0000 returns low fuse, 0x0003 high fuse
// (RULE21) lock and enable bits clear on readback, load or store timeout
// (RULE22) readback: programmed bit reads zero, unprogrammed reads one
// (RULE23) write in progress survives reset and runs to completion
// (RULE24) store enable arms four cycles, stays set during erase or write
// (RULE25) other low five bit codes cause no operation
// (RULE26) busy flag set at concurrent section start, cleared by buffer load
// (RULE27) windows counted in core cycles from control write
// (RULE28) store after window expiry causes no flash operation
// ==========================================================
// flash self-program sequencer top
module fsp_sequencer (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // cpu instruction side
   input wire logic store_exec,
   input wire logic load_exec,
   input wire logic [15:0] z_ptr,
   input wire logic [7:0] data_low_reg,
   input wire logic [7:0] data_high_reg,
   output logic readback_valid,
   output logic [7:0] readback_data,
   output logic cpu_halt,
   output logic rww_read_block,
   output logic irq_req,
   // eeprom and nonvolatile bits
   input wire logic eeprom_write_busy,
   input wire logic [7:0] fuse_low_byte,
   input wire logic [7:0] fuse_high_byte,
   input wire logic [5:0] lock_bits_nv,
   // flash array
   output logic flash_start,
   output logic [1:0] flash_op,
   output logic [6:0] flash_page,
   output logic [3:0] flash_lock_data,
   input wire logic flash_busy,
   input wire logic [4:0] buf_rd_idx,
   output logic [15:0] buf_rd_data
);
   typedef struct packed {
      logic irq_en;
      logic busy_flag;
      logic [4:0] ctrl_low;
      fsp_pkg::fsp_state_t state;
      logic [6:0] page;
      logic is_halting_section;
      logic [1:0] op;
      logic [3:0] lock_data;
      logic [7:0] rdata;
      logic rb_valid;
      logic [7:0] rb_data;
      logic halt;
      logic block;
      logic irq;
      logic start;
   } fsp_seq_state_t;

   fsp_seq_state_t cur;
   fsp_seq_state_t next_cur;
   logic rst_meta;
   logic rst_n;
   logic [2:0] win_count;
   logic arm;
   logic disarm;
   logic buf_wr;
   logic buf_clr;
   logic buf_any;
   logic ctrl_hit;
   logic code_ok;
   logic store_ok;
   logic load_ok;
   logic [6:0] z_page;

   // ==========================================================
   // reset release through two flops
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ==========================================================
   // arming window and page buffer
   fsp_arm_timer #(
      .W(3)
   ) u_timer (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .arm(arm),
      .arm_value(fsp_pkg::STORE_WIN),
      .disarm(disarm),
      .count(win_count)
   );

   fsp_page_buf #(
      .WORDS(32),
      .WIDTH(16),
      .IDXW(5)
   ) u_buf (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .wr_en(buf_wr),
      .wr_idx(z_ptr[fsp_pkg::WORD_MSB:fsp_pkg::WORD_LSB]),
      .wr_data({data_high_reg, data_low_reg}),
      .clear(buf_clr),
      .rd_idx(buf_rd_idx),
      .rd_data(buf_rd_data),
      .any_loaded(buf_any)
   );

   // ==========================================================
   // decode helpers
   assign ctrl_hit = reg_addr == fsp_pkg::CTRL_ADDR;
   assign z_page = z_ptr[fsp_pkg::PAGE_MSB:fsp_pkg::PAGE_LSB];
   // (RULE25) only five codes accepted
   assign code_ok = reg_wdata[4:0] == fsp_pkg::CODE_LOAD ||
      reg_wdata[4:0] == fsp_pkg::CODE_ERASE ||
      reg_wdata[4:0] == fsp_pkg::CODE_WRITE ||
      reg_wdata[4:0] == fsp_pkg::CODE_LOCK ||
      reg_wdata[4:0] == fsp_pkg::CODE_REEN;
   // (RULE28) store only inside live window
   assign store_ok = store_exec && win_count != 3'h0 && cur.ctrl_low[0] &&
      cur.state == fsp_pkg::ST_IDLE && !eeprom_write_busy;
   // (RULE19) readback load within three cycles
   assign load_ok = load_exec && cur.ctrl_low == fsp_pkg::CODE_LOCK &&
      win_count >= fsp_pkg::LOAD_MIN && cur.state == fsp_pkg::ST_IDLE &&
      !eeprom_write_busy;

   // ==========================================================
   // next state
   always_comb begin
      next_cur = cur;
      next_cur.start = 1'b0;
      next_cur.rb_valid = 1'b0;
      next_cur.rdata = 8'h00;
      arm = 1'b0;
      disarm = 1'b0;
      buf_wr = 1'b0;
      buf_clr = 1'b0;
      // control write; (RULE18) code refused during eeprom write, interrupt enable bit still taken
      if (reg_wr && ctrl_hit) begin
         next_cur.irq_en = reg_wdata[fsp_pkg::IRQ_EN_BIT];
         if (code_ok && cur.state == fsp_pkg::ST_IDLE && !eeprom_write_busy) begin
            next_cur.ctrl_low = reg_wdata[4:0];
            // (RULE27) window starts at this write
            arm = 1'b1;
         end
      end
      // (RULE9) eeprom write drops partial buffer
      if (eeprom_write_busy && buf_any) begin
         buf_clr = 1'b1;
      end
      case (cur.state)
         fsp_pkg::ST_IDLE: begin
            // (RULE23) rejoin an operation still running after reset
            if (flash_busy) begin
               next_cur.state = fsp_pkg::ST_WAIT;
               next_cur.ctrl_low = fsp_pkg::CODE_LOAD;
               // page unknown after reset: treat as halting section
               next_cur.is_halting_section = 1'b1;
               next_cur.halt = 1'b1;
               next_cur.block = 1'b1;
            end else if (store_ok) begin
               case (cur.ctrl_low)
                  fsp_pkg::CODE_LOAD: begin
                     // (RULE6) data pair to addressed word
                     // (RULE3) byte select bit not part of word index
                     buf_wr = 1'b1;
                     // (RULE26) load clears busy flag
                     next_cur.busy_flag = 1'b0;
                     next_cur.ctrl_low = 5'h00;
                     disarm = 1'b1;
                  end
                  fsp_pkg::CODE_ERASE, fsp_pkg::CODE_WRITE: begin
                     // (RULE1) latch page at start
                     // (RULE4) page field only for erase
                     // (RULE10) page field only for write
                     next_cur.page = z_page;
                     next_cur.is_halting_section = z_page >= fsp_pkg::RWW_PAGES;
                     next_cur.op = (cur.ctrl_low == fsp_pkg::CODE_ERASE) ?
                        fsp_pkg::OP_ERASE : fsp_pkg::OP_WRITE;
                     next_cur.start = 1'b1;
                     next_cur.state = fsp_pkg::ST_START;
                     // (RULE5) halt for halting section erase
                     // (RULE11) halt for halting section write
                     next_cur.halt = z_page >= fsp_pkg::RWW_PAGES;
                     // (RULE13) block concurrent section while busy
                     // (RULE26) busy flag set at start
                     next_cur.block = 1'b1;
                     if (z_page < fsp_pkg::RWW_PAGES) begin
                        next_cur.busy_flag = 1'b1;
                     end
                  end
                  fsp_pkg::CODE_LOCK: begin
                     // (RULE2) pointer ignored, page untouched
                     // (RULE15) data bits 5..2 select lock bits
                     next_cur.op = fsp_pkg::OP_LOCK;
                     next_cur.lock_data =
                        data_low_reg[fsp_pkg::LOCKD_MSB:fsp_pkg::LOCKD_LSB];
                     next_cur.start = 1'b1;
                     next_cur.state = fsp_pkg::ST_START;
                     // (RULE17) no halt, no block
                     next_cur.halt = 1'b0;
                     next_cur.block = 1'b0;
                  end
                  fsp_pkg::CODE_REEN: begin
                     // (RULE7) re-enable clears buffer
                     buf_clr = 1'b1;
                     next_cur.busy_flag = 1'b0;
                     next_cur.ctrl_low = 5'h00;
                     disarm = 1'b1;
                  end
                  default: begin
                     next_cur.ctrl_low = 5'h00;
                  end
               endcase
            end else if (load_ok) begin
               // (RULE20) fuse bytes by full pointer
               // (RULE22) bits pass as stored, zero means programmed
               next_cur.rb_valid = 1'b1;
               case (z_ptr)
                  fsp_pkg::Z_LOCK: next_cur.rb_data = {fsp_pkg::LOCK_UNUSED, lock_bits_nv};
                  fsp_pkg::Z_FUSE_LO: next_cur.rb_data = fuse_low_byte;
                  fsp_pkg::Z_FUSE_HI: next_cur.rb_data = fuse_high_byte;
                  default: next_cur.rb_data = fsp_pkg::RB_NONE;
               endcase
               // (RULE21) readback done clears bits
               next_cur.ctrl_low = 5'h00;
               disarm = 1'b1;
            end else if (win_count == 3'h0 && !arm) begin
               // (RULE21) window timeout clears bits
               next_cur.ctrl_low = 5'h00;
            end
         end
         fsp_pkg::ST_START: begin
            next_cur.state = fsp_pkg::ST_WAIT;
         end
         fsp_pkg::ST_WAIT: begin
            // (RULE24) store enable held until array idle
            if (!flash_busy) begin
               next_cur.state = fsp_pkg::ST_IDLE;
               next_cur.ctrl_low = 5'h00;
               next_cur.halt = 1'b0;
               next_cur.block = 1'b0;
               // (RULE7) page write empties buffer
               if (cur.op == fsp_pkg::OP_WRITE) begin
                  buf_clr = 1'b1;
               end
            end
         end
         default: begin
            next_cur.state = fsp_pkg::ST_IDLE;
         end
      endcase
      // (RULE12) level request while store enable clear
      next_cur.irq = next_cur.irq_en && !next_cur.ctrl_low[0];
      // register read, unmapped reads zero
      if (reg_rd && ctrl_hit) begin
         next_cur.rdata = {cur.irq_en, cur.busy_flag, 1'b0, cur.ctrl_low};
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // outputs straight from flops
   assign reg_rdata = cur.rdata;
   assign readback_valid = cur.rb_valid;
   assign readback_data = cur.rb_data;
   assign cpu_halt = cur.halt;
   assign rww_read_block = cur.block;
   assign irq_req = cur.irq;
   assign flash_start = cur.start;
   assign flash_op = cur.op;
   assign flash_page = cur.page;
   assign flash_lock_data = cur.lock_data;

   // ==========================================================
   // assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   store_expired_a: assert property ( // (RULE28)
      (store_exec && win_count == 3'h0) |=> !flash_start)
      else $error("store outside window started flash");
   eeprom_refuse_a: assert property ( // (RULE18)
      (eeprom_write_busy && (store_exec || load_exec)) |=> !flash_start && !readback_valid)
      else $error("operation accepted during eeprom write");
   page_latch_a: assert property ( // (RULE1)
      (store_ok && cur.ctrl_low == fsp_pkg::CODE_ERASE) |=>
         flash_start && flash_page == $past(z_page) ##1 $stable(flash_page))
      else $error("page not latched at start");
   lock_open_a: assert property ( // (RULE17)
      (flash_op == fsp_pkg::OP_LOCK && cur.state != fsp_pkg::ST_IDLE) |->
         !cpu_halt && !rww_read_block)
      else $error("lock programming blocked flash");
   irq_level_a: assert property ( // (RULE12)
      (cur.irq_en && !cur.ctrl_low[0] && !reg_wr && !flash_busy) |=> irq_req)
      else $error("interrupt not held");
   lock_read_a: assert property ( // (RULE19)
      (load_ok && z_ptr == fsp_pkg::Z_LOCK) |=>
         readback_valid && readback_data[5:0] == $past(lock_bits_nv))
      else $error("lock readback wrong");
   arm_timeout_a: assert property ( // (RULE21)
      arm ##1 (!store_exec && !load_exec && !reg_wr)[*4] ##1 !reg_wr |=>
         cur.ctrl_low == 5'h00)
      else $error("arming bits not cleared on timeout");
   halt_halting_section_a: assert property ( // (RULE11)
      (cur.state == fsp_pkg::ST_WAIT && flash_op != fsp_pkg::OP_LOCK) |->
         cpu_halt == cur.is_halting_section)
      else $error("halt does not match section");
   busy_hold_a: assert property ( // (RULE24)
      (cur.state == fsp_pkg::ST_WAIT && flash_busy) |=> cur.ctrl_low[0])
      else $error("store enable dropped while busy");
   buf_clear_a: assert property ( // (RULE7)
      (cur.state == fsp_pkg::ST_WAIT && !flash_busy && cur.op == fsp_pkg::OP_WRITE)
         |=> !buf_any)
      else $error("buffer kept after page write");
   rww_busy_a: assert property ( // (RULE13)
      (flash_start && !cur.is_halting_section && flash_op != fsp_pkg::OP_LOCK) |->
         cur.busy_flag && rww_read_block)
      else $error("busy flag not set at start");

   erase_seen_c: cover property (
      store_ok && cur.ctrl_low == fsp_pkg::CODE_ERASE);
   load_seen_c: cover property (buf_wr ##1 buf_any);
   readback_seen_c: cover property (readback_valid);
   lock_seen_c: cover property (flash_start && flash_op == fsp_pkg::OP_LOCK);
endmodule : fsp_sequencer

//--- core/fsp_pkg.sv
// ==========================================================
// constants for the flash self-program sequencer
package fsp_pkg;
   // register port map
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam int IRQ_EN_BIT = 7;
   localparam int BUSY_BIT = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // low five control bits: valid command codes
   localparam logic [4:0] CODE_LOAD = 5'h01;
   localparam logic [4:0] CODE_ERASE = 5'h03;
   localparam logic [4:0] CODE_WRITE = 5'h05;
   localparam logic [4:0] CODE_LOCK = 5'h09;
   localparam logic [4:0] CODE_REEN = 5'h11;
   // arming windows in core_clk cycles
   localparam logic [2:0] STORE_WIN = 3'h4;
   localparam logic [2:0] LOAD_WIN = 3'h3;
   localparam logic [2:0] LOAD_MIN = STORE_WIN - LOAD_WIN + 3'h1;
   // pointer fields
   localparam int PAGE_LSB = 6;
   localparam int PAGE_MSB = 12;
   localparam int WORD_LSB = 1;
   localparam int WORD_MSB = 5;
   localparam int LOCKD_LSB = 2;
   localparam int LOCKD_MSB = 5;
   // pages below this limit belong to the concurrent read section
   localparam logic [6:0] RWW_PAGES = 7'h60;
   // readback pointer values
   localparam logic [15:0] Z_FUSE_LO = 16'h0000;
   localparam logic [15:0] Z_LOCK = 16'h0001;
   localparam logic [15:0] Z_FUSE_HI = 16'h0003;
   localparam logic [1:0] LOCK_UNUSED = 2'h3;
   localparam logic [7:0] RB_NONE = 8'hff;
   // flash array operations
   localparam logic [1:0] OP_NONE = 2'h0;
   localparam logic [1:0] OP_ERASE = 2'h1;
   localparam logic [1:0] OP_WRITE = 2'h2;
   localparam logic [1:0] OP_LOCK = 2'h3;
   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_START = 2'b01,
      ST_WAIT = 2'b10
   } fsp_state_t;
endpackage : fsp_pkg

//--- core/fsp_arm_timer.sv
`timescale 1ns/1ps
// ==========================================================
// arming window down-counter
module fsp_arm_timer #(
   parameter int W = 3
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // control
   input wire logic arm,
   input wire logic [W-1:0] arm_value,
   input wire logic disarm,
   // state
   output logic [W-1:0] count
);
   typedef struct packed {
      logic [W-1:0] count;
   } fsp_tmr_state_t;

   fsp_tmr_state_t cur;
   fsp_tmr_state_t next_cur;

   // load on arm, drop on disarm, else count down to zero
   always_comb begin
      next_cur = cur;
      if (arm) begin
         next_cur.count = arm_value;
      end else if (disarm) begin
         next_cur.count = '0;
      end else if (cur.count != '0) begin
         next_cur.count = cur.count - W'(1);
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign count = cur.count;
endmodule : fsp_arm_timer

//--- core/fsp_page_buf.sv
`timescale 1ns/1ps
// ==========================================================
// temporary page buffer, one flop word per entry
module fsp_page_buf #(
   parameter int WORDS = 32,
   parameter int WIDTH = 16,
   parameter int IDXW = 5
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // load side
   input wire logic wr_en,
   input wire logic [IDXW-1:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic clear,
   // array side
   input wire logic [IDXW-1:0] rd_idx,
   output logic [WIDTH-1:0] rd_data,
   output logic any_loaded
);
   typedef struct packed {
      logic [WORDS-1:0][WIDTH-1:0] mem;
      logic [WORDS-1:0] used;
      logic [WIDTH-1:0] rd_data;
   } fsp_buf_state_t;

   fsp_buf_state_t cur;
   fsp_buf_state_t next_cur;
   wire [WORDS-1:0][WIDTH-1:0] next_mem;
   wire [WORDS-1:0] next_used;

   // per entry: clear wins, else write when addressed
   for (genvar i = 0; i < WORDS; i++) begin : g_entry
      assign next_mem[i] = clear ? '0 :
         (wr_en && wr_idx == IDXW'(i)) ? wr_data : cur.mem[i];
      assign next_used[i] = clear ? 1'b0 :
         (wr_en && wr_idx == IDXW'(i)) ? 1'b1 : cur.used[i];
   end

   // assemble next state, registered read port
   always_comb begin
      next_cur = cur;
      next_cur.mem = next_mem;
      next_cur.used = next_used;
      next_cur.rd_data = cur.mem[rd_idx];
   end

   // reset empties the buffer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign rd_data = cur.rd_data;
   assign any_loaded = |cur.used;
endmodule : fsp_page_buf

//--- test/fsp_flash_model.sv
`timescale 1ns/1ps
// ==========================================================
// flash array stand-in, busy for a fixed span per start
module fsp_flash_model #(
   parameter int DUR = 20
) (
   // clock
   input wire logic core_clk,
   // sequencer side
   input wire logic flash_start,
   output logic flash_busy
);
   int cnt = 0;
   // busy from the cycle after start; no reset, an operation survives it
   always @(posedge core_clk) begin
      if (flash_start) begin
         cnt <= DUR;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end
   assign flash_busy = (cnt != 0);
endmodule : fsp_flash_model

//--- test/tb_flash_self_program_sequencer.sv
`timescale 1ns/1ps
// ==========================================================
// bench for the self-program sequencer
module tb_flash_self_program_sequencer;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0, store_exec = 1'b0, load_exec = 1'b0;
   logic [15:0] z_ptr = 16'h0000, buf_rd_data;
   logic [7:0] data_low_reg = 8'h00, data_high_reg = 8'h00, readback_data;
   logic [7:0] fuse_low_byte = 8'h00, fuse_high_byte = 8'h00;
   logic [5:0] lock_bits_nv = 6'h00;
   logic eeprom_write_busy = 1'b0, flash_busy, flash_start, readback_valid;
   logic cpu_halt, rww_read_block, irq_req;
   logic [1:0] flash_op;
   logic [6:0] flash_page;
   logic [3:0] flash_lock_data;
   logic [4:0] buf_rd_idx = 5'h00;
   logic [7:0] v;
   logic [6:0] p;
   int err_total = 0, n_checks = 0;
   int exp_buf[32];
   int zs[3] = '{0, 1, 3};
   // ==========================================================
   // design and flash stand-in
   fsp_sequencer i_dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .store_exec(store_exec), .load_exec(load_exec), .z_ptr(z_ptr),
      .data_low_reg(data_low_reg), .data_high_reg(data_high_reg),
      .readback_valid(readback_valid), .readback_data(readback_data), .cpu_halt(cpu_halt),
      .rww_read_block(rww_read_block), .irq_req(irq_req),
      .eeprom_write_busy(eeprom_write_busy), .fuse_low_byte(fuse_low_byte),
      .fuse_high_byte(fuse_high_byte), .lock_bits_nv(lock_bits_nv),
      .flash_start(flash_start), .flash_op(flash_op), .flash_page(flash_page),
      .flash_lock_data(flash_lock_data), .flash_busy(flash_busy),
      .buf_rd_idx(buf_rd_idx), .buf_rd_data(buf_rd_data));
   fsp_flash_model i_flash (.core_clk(core_clk), .flash_start(flash_start),
      .flash_busy(flash_busy));
   // 50 ns clock
   always #25 core_clk = ~core_clk;
   // ==========================================================
   // shared tasks
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic spm(input logic [15:0] z, input logic [7:0] dl, input logic [7:0] dh);
      z_ptr <= z;
      data_low_reg <= dl;
      data_high_reg <= dh;
      store_exec <= 1'b1;
      @(posedge core_clk);
      store_exec <= 1'b0;
      #1;
   endtask : spm
   task automatic wait_idle();
      for (int i = 0; i < 100; i++) begin
         @(posedge core_clk);
         #1;
         if (flash_busy === 1'b0) break;
      end
      chk("flash idle", flash_busy, 16'h0000);
      repeat (2) @(posedge core_clk);
      #1;
   endtask : wait_idle
   // byte select set on purpose: stores must ignore it
   task automatic load(input int w);
      logic [15:0] d;
      d = 16'($urandom);
      wr(8'h00, 8'h01);
      spm({10'h000, w[4:0], 1'b1}, d[7:0], d[15:8]);
      exp_buf[w] = d;
   endtask : load
   task automatic bufchk(input int w);
      @(posedge core_clk);
      buf_rd_idx <= w[4:0];
      @(posedge core_clk);
      #1 chk("buffer word", buf_rd_data, 16'(exp_buf[w]));
   endtask : bufchk
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // ==========================================================
   // watchdog
   initial begin
      repeat (5000) @(posedge core_clk);
      err_total++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      void'($urandom(32'h39a7));
      fuse_low_byte = 8'($urandom);
      fuse_high_byte = 8'($urandom);
      lock_bits_nv = 6'($urandom);
      foreach (exp_buf[i]) exp_buf[i] = 0;
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(8'h00, v);
      chk("ctrl reset", v, 16'h0000);
      rd(8'h5a, v);
      chk("unmapped", v, 16'h0000);
      for (int i = 0; i < 4; i++) load(8 * i + $urandom_range(7));
      for (int i = 0; i < 32; i += 8) bufchk(i + 1);
      for (int i = 0; i < 32; i++) if (exp_buf[i] != 0) bufchk(i);
      @(posedge core_clk);
      eeprom_write_busy <= 1'b1;
      foreach (exp_buf[i]) exp_buf[i] = 0;
      wr(8'h00, 8'h03);
      spm(16'h0040, 8'h00, 8'h00);
      chk("erase refused", flash_start, 0);
      rd(8'h00, v);
      chk("ctrl refused", v, 16'h0000);
      eeprom_write_busy <= 1'b0;
      foreach (exp_buf[i]) bufchk(i);
      p = 7'($urandom_range(95));
      wr(8'h00, 8'h83);
      spm({3'h7, p, 6'h3f}, 8'($urandom), 8'($urandom));
      chk("start", flash_start, 1);
      chk("op", flash_op, 1);
      chk("page", flash_page, 16'(p));
      chk("halt", cpu_halt, 0);
      chk("block", rww_read_block, 1);
      chk("irq busy", irq_req, 0);
      @(posedge core_clk);
      z_ptr <= 16'h0000;
      wait_idle();
      chk("page held", flash_page, 16'(p));
      chk("irq idle", irq_req, 1);
      rd(8'h00, v);
      chk("busy flag", v, 16'h00c0);
      load(3);
      rd(8'h00, v);
      chk("busy by load", v, 16'h0000);
      wr(8'h00, 8'h05);
      spm(16'h1c00, 8'h00, 8'h00);
      chk("op", flash_op, 2);
      chk("page", flash_page, 16'h0070);
      chk("halt", cpu_halt, 1);
      chk("block", rww_read_block, 1);
      wait_idle();
      exp_buf[3] = 0;
      bufchk(3);
      // section re-enabled before any read of it
      load(4);
      wr(8'h00, 8'h11);
      spm(16'h0000, 8'h00, 8'h00);
      exp_buf[4] = 0;
      bufchk(4);
      // lock set ignores pointer, no halt
      v = 8'($urandom) | 8'hc3;
      wr(8'h00, 8'h09);
      spm(16'($urandom), v, 8'($urandom));
      chk("op", flash_op, 3);
      chk("lock data", flash_lock_data, 16'(v[5:2]));
      chk("halt", cpu_halt, 0);
      chk("block", rww_read_block, 0);
      wait_idle();
      // readback of fuse and lock bytes
      foreach (zs[i]) begin
         wr(8'h00, 8'h09);
         @(posedge core_clk);
         load_exec <= 1'b1;
         z_ptr <= 16'(zs[i]);
         @(posedge core_clk);
         load_exec <= 1'b0;
         #1 chk("rb valid", readback_valid, 1);
         chk("rb data", readback_data, (zs[i] == 0) ? 16'(fuse_low_byte) : (zs[i] == 1) ?
            16'({2'b11, lock_bits_nv}) : 16'(fuse_high_byte));
         rd(8'h00, v);
         chk("ctrl after rb", v, 16'h0000);
      end
      wr(8'h00, 8'h09);
      repeat (3) @(posedge core_clk);
      load_exec <= 1'b1;
      @(posedge core_clk);
      load_exec <= 1'b0;
      #1 chk("late load", readback_valid, 0);
      rd(8'h00, v);
      chk("ctrl timeout", v, 16'h0000);
      wr(8'h00, 8'h03);
      repeat (4) @(posedge core_clk);
      spm(16'h0040, 8'h00, 8'h00);
      chk("late store", flash_start, 0);
      wr(8'h00, 8'h07);
      rd(8'h00, v);
      chk("bad code ctrl", v, 16'h0000);
      spm(16'h0040, 8'h00, 8'h00);
      chk("bad code", flash_start, 0);
      load(6);
      wr(8'h00, 8'h05);
      spm(16'h1c00, 8'h00, 8'h00);
      @(posedge core_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge core_clk);
      #1 chk("halt kept", cpu_halt, 1);
      wait_idle();
      chk("halt end", cpu_halt, 0);
      exp_buf[6] = 0;
      bufchk(6);
      tally_and_finish();
   end
endmodule : tb_flash_self_program_sequencer
